// ==== psa_pkg.sv ====
package psa_pkg;
    // ----------------------------------------
    // register map and field layout
    // ----------------------------------------
    localparam logic [10:0] SIG_RED_ADDR   = 11'h010;
    localparam logic [10:0] SIG_GREEN_ADDR = 11'h011;
    localparam logic [10:0] SIG_BLUE_ADDR  = 11'h012;
    localparam logic [10:0] SIG_EXTRA_ADDR = 11'h013;
    localparam logic [10:0] CMD4_ADDR      = 11'h008;
    localparam int          CMD4_CLKEN_BIT = 5;
    localparam int          CMD4_RESET_BIT = 6;
    localparam int          CMD4_FDBK_BIT  = 7;
    localparam logic [7:0]  CMD4_RESET_VAL = 8'h40;
    localparam int          PIX_W          = 30;
    localparam int          SIG_W          = 33;
    // feedback taps for x^33 + x^20 + 1 (maximal length)
    localparam logic [32:0] SIG_POLY       = 33'h0_0010_0001;
    // host controller own register byte addresses
    localparam logic [7:0]  HC_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  HC_STAT_ADDR   = 8'h04;
    localparam logic [7:0]  HC_SIG_LO_ADDR = 8'h08;
    localparam logic [7:0]  HC_SIG_HI_ADDR = 8'h0C;
    localparam int          HC_CTRL_ARM    = 0;
    localparam int          HC_CTRL_STOP   = 1;
    localparam int          HC_STAT_BUSY   = 0;
    localparam int          HC_STAT_DONE   = 1;
    localparam int          HC_STAT_ARMED  = 2;
    // pipeline drain wait before freezing the signature
    localparam int          DRAIN_CYCLES   = 20;
    localparam logic [1:0]  AXI_OKAY       = 2'b00;
    localparam logic [1:0]  AXI_SLVERR     = 2'b10;
endpackage

// ==== psa_port_if.sv ====
`timescale 1ns/1ns
// microprocessor register port between host controller and device
interface psa_port_if;
    logic        cmdValid;   // one-cycle access strobe
    logic        cmdWrite;
    logic [10:0] cmdAddr;
    logic [9:0]  wrData;
    logic [9:0]  rdData;
    logic        rdValid;    // one-cycle read answer
    logic        busMode10;  // 1: 10-bit bus, 0: 8-bit bus
    modport device (input cmdValid, cmdWrite, cmdAddr, wrData, busMode10, output rdData, rdValid);
    modport host   (output cmdValid, cmdWrite, cmdAddr, wrData, busMode10, input rdData, rdValid);
endinterface

// ==== psa_lfsr.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// signature register core
// ----------------------------------------
module psa_lfsr
    import psa_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // control
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic             feedback,
    input  wire logic [PIX_W-1:0] pixel,
    // result
    output logic      [SIG_W-1:0] signature
);
    logic [SIG_W-1:0] sig_reg;
    logic [SIG_W-1:0] sig_next;
    logic [SIG_W-1:0] pixWide;

    // shift with taps, then xor pixel bit n into stage n
    always_comb begin
        pixWide = {{(SIG_W-PIX_W){1'b0}}, pixel};
        if (feedback) begin
            sig_next = {sig_reg[SIG_W-2:0], 1'b0} ^ (sig_reg[SIG_W-1] ? SIG_POLY : '0) ^ pixWide;
        end else begin
            sig_next = pixWide;
        end
    end

    // clear takes priority over step so a reset toggle always starts clean
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sig_reg <= '0;
        end else if (clear) begin
            sig_reg <= '0;
        end else if (step) begin
            sig_reg <= sig_next;
        end
    end

    assign signature = sig_reg;
endmodule

// ==== psa_device.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// device end: command register four and signature readback
// ----------------------------------------
module psa_device
    import psa_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // register port
    psa_port_if.device            port,
    // pixel datapath
    input  wire logic [PIX_W-1:0] pixelIn,
    input  wire logic             blankIn,
    output logic      [PIX_W-1:0] pixelOut,
    // control bits of command register four
    output logic                  sigClockEnable,
    output logic                  sigFeedback
);
    logic [7:0]       cmd4_reg;
    logic             resetBitPrev_reg;
    logic             lowSeen_reg;
    logic [9:0]       rdData_reg;
    logic             rdValid_reg;
    logic             readLsb_reg;
    logic [9:0]       readWord;
    logic             sigClear;
    logic [SIG_W-1:0] signature;

    assign sigClockEnable = cmd4_reg[CMD4_CLKEN_BIT];
    assign sigFeedback    = cmd4_reg[CMD4_FDBK_BIT];

    // command register four; result registers ignore writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd4_reg <= CMD4_RESET_VAL;
        end else if (port.cmdValid && port.cmdWrite && port.cmdAddr == CMD4_ADDR) begin
            cmd4_reg <= port.wrData[7:0];
        end
    end

    // reset is armed by a low and fired by the following high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resetBitPrev_reg <= 1'b1;
            lowSeen_reg      <= 1'b0;
        end else begin
            resetBitPrev_reg <= cmd4_reg[CMD4_RESET_BIT];
            if (!cmd4_reg[CMD4_RESET_BIT]) begin
                lowSeen_reg <= 1'b1;
            end else if (sigClear) begin
                lowSeen_reg <= 1'b0;
            end
        end
    end
    assign sigClear = lowSeen_reg && cmd4_reg[CMD4_RESET_BIT] && !resetBitPrev_reg;

    // analyzer sits in front of the decoders, data passes unchanged
    psa_lfsr u_lfsr (
        .core_clk  (core_clk),
        .rst       (rst),
        .clear     (sigClear),
        .step      (sigClockEnable && blankIn),
        .feedback  (sigFeedback),
        .pixel     (pixelIn),
        .signature (signature)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pixelOut <= '0;
        end else begin
            pixelOut <= pixelIn;
        end
    end

    // result word selection
    always_comb begin
        unique case (port.cmdAddr)
            SIG_RED_ADDR:   readWord = signature[30:21];
            SIG_GREEN_ADDR: readWord = signature[20:11];
            SIG_BLUE_ADDR:  readWord = signature[10:1];
            SIG_EXTRA_ADDR: readWord = {7'h00, signature[32:31], signature[0]};
            CMD4_ADDR:      readWord = {2'b00, cmd4_reg};
            default:        readWord = 10'h000;
        endcase
    end

    // 8-bit mode: first read gives bits 9:2, second gives bits 1:0 like the palette
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData_reg  <= '0;
            rdValid_reg <= 1'b0;
            readLsb_reg <= 1'b0;
        end else begin
            rdValid_reg <= port.cmdValid && !port.cmdWrite;
            if (port.cmdValid && !port.cmdWrite) begin
                if (port.busMode10) begin
                    rdData_reg  <= readWord;
                    readLsb_reg <= 1'b0;
                end else if (!readLsb_reg) begin
                    rdData_reg  <= {2'b00, readWord[9:2]};
                    readLsb_reg <= 1'b1;
                end else begin
                    rdData_reg  <= {8'h00, readWord[1:0]};
                    readLsb_reg <= 1'b0;
                end
            end else if (port.cmdValid) begin
                readLsb_reg <= 1'b0;
            end
        end
    end

    assign port.rdData  = rdData_reg;
    assign port.rdValid = rdValid_reg;
endmodule

// ==== psa_host.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// host end: axi4-lite controlled capture sequencer
// ----------------------------------------
module psa_host
    import psa_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // video timing
    input  wire logic        blankIn,
    input  wire logic        vretrace,
    // device register port
    psa_port_if.host         port
);
    typedef enum logic [7:0] {
        S_IDLE  = 8'b0000_0001, S_ARM   = 8'b0000_0010, S_LOW = 8'b0000_0100,
        S_HIGH  = 8'b0000_1000, S_WAITA = 8'b0001_0000, S_RUN = 8'b0010_0000,
        S_DRAIN = 8'b0100_0000, S_READ  = 8'b1000_0000
    } psa_state_t;

    psa_state_t  state_reg;
    logic [4:0]  drain_reg;
    logic [1:0]  rdIdx_reg;
    logic        rdPend_reg;
    logic [32:0] sig_reg;
    logic        done_reg;
    logic        awHeld_reg, wHeld_reg;
    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic        armReq;
    logic        wStrb0_reg;

    // -------- axi write: latch address and data in either order
    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            awHeld_reg <= 1'b0; wHeld_reg <= 1'b0; awAddr_reg <= '0; wData_reg <= '0;
            wStrb0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin awHeld_reg <= 1'b1; awAddr_reg <= s_axi_awaddr; end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg  <= 1'b1;
                wData_reg  <= s_axi_wdata;
                wStrb0_reg <= s_axi_wstrb[0]; // strobe is only valid alongside wvalid
            end
            if (awHeld_reg && wHeld_reg) begin
                awHeld_reg <= 1'b0; wHeld_reg <= 1'b0; s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_reg == HC_CTRL_ADDR) ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // only arm is honoured; a capture stops by itself after one frame
    assign armReq = awHeld_reg && wHeld_reg && awAddr_reg == HC_CTRL_ADDR
                    && wStrb0_reg && wData_reg[HC_CTRL_ARM];

    // -------- axi read
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0; s_axi_rdata <= '0; s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= AXI_OKAY;
            unique case (s_axi_araddr)
                HC_CTRL_ADDR:   s_axi_rdata <= '0;
                HC_STAT_ADDR:   s_axi_rdata <= {29'h0, state_reg == S_WAITA || state_reg == S_RUN,
                                                done_reg, state_reg != S_IDLE};
                HC_SIG_LO_ADDR: s_axi_rdata <= sig_reg[31:0];
                HC_SIG_HI_ADDR: s_axi_rdata <= {31'h0, sig_reg[32]};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -------- capture sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE; drain_reg <= '0; rdIdx_reg <= '0; rdPend_reg <= 1'b0;
            sig_reg <= '0; done_reg <= 1'b0;
            port.cmdValid <= 1'b0; port.cmdWrite <= 1'b0; port.cmdAddr <= '0; port.wrData <= '0;
        end else begin
            port.cmdValid <= 1'b0;
            unique case (state_reg)
                S_IDLE: if (armReq) begin
                    done_reg <= 1'b0; state_reg <= S_ARM;
                end
                S_ARM: if (vretrace) begin // enable and feedback high, reset bit low
                    port.cmdValid <= 1'b1; port.cmdWrite <= 1'b1; port.cmdAddr <= CMD4_ADDR;
                    port.wrData <= 10'h0A0; state_reg <= S_HIGH;
                end
                S_HIGH: begin // reset bit back high completes the toggle
                    port.cmdValid <= 1'b1; port.cmdWrite <= 1'b1; port.wrData <= 10'h0E0;
                    state_reg <= S_WAITA;
                end
                S_WAITA: if (blankIn) state_reg <= S_RUN; // no port traffic while accumulating
                S_RUN: if (vretrace) begin
                    drain_reg <= 5'(DRAIN_CYCLES); state_reg <= S_DRAIN;
                end
                S_DRAIN: if (drain_reg != 5'd0) begin
                    drain_reg <= drain_reg - 5'd1;
                end else begin // clear enable, keep reset high
                    port.cmdValid <= 1'b1; port.cmdWrite <= 1'b1; port.wrData <= 10'h0C0;
                    rdIdx_reg <= '0; rdPend_reg <= 1'b0; state_reg <= S_READ;
                end
                S_READ: if (!rdPend_reg) begin
                    port.cmdValid <= 1'b1; port.cmdWrite <= 1'b0;
                    port.cmdAddr <= SIG_RED_ADDR + {9'h0, rdIdx_reg}; rdPend_reg <= 1'b1;
                end else if (port.rdValid) begin
                    rdPend_reg <= 1'b0;
                    unique case (rdIdx_reg)
                        2'd0: sig_reg[30:21] <= port.rdData;
                        2'd1: sig_reg[20:11] <= port.rdData;
                        2'd2: sig_reg[10:1]  <= port.rdData;
                        2'd3: {sig_reg[32:31], sig_reg[0]} <= port.rdData[2:0];
                    endcase
                    rdIdx_reg <= rdIdx_reg + 2'd1;
                    if (rdIdx_reg == 2'd3) begin
                        done_reg <= 1'b1; state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
    assign port.busMode10 = 1'b1; // host always uses the 10-bit bus
endmodule

// ==== psa_assertions.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// checker on the register port between the two ends
// ----------------------------------------
module psa_assertions
    import psa_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // register port
    input wire logic        cmdValid,
    input wire logic        cmdWrite,
    input wire logic [10:0] cmdAddr,
    input wire logic [9:0]  wrData,
    input wire logic [9:0]  rdData,
    input wire logic        rdValid,
    input wire logic        busMode10,
    // command register four bits
    input wire logic        sigClockEnable,
    input wire logic        sigFeedback,
    // video timing
    input wire logic        blankIn
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic rdReq;
    logic wrCmd;
    // decoded strobes, kept plain so the properties stay readable
    assign rdReq = cmdValid && !cmdWrite;
    assign wrCmd = cmdValid && cmdWrite && (cmdAddr == CMD4_ADDR);
    logic [7:0] sinceActive_reg;
    // blank cycles since the last active pixel, saturating so a long retrace cannot wrap
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sinceActive_reg <= 8'h00;
        end else if (blankIn) begin
            sinceActive_reg <= 8'h00;
        end else if (sinceActive_reg != 8'hFF) begin
            sinceActive_reg <= sinceActive_reg + 8'h01;
        end
    end
    property p_quiet_active; sigClockEnable && blankIn |-> !wrCmd; endproperty
    a_quiet_active: assert property (p_quiet_active)
        else $error("command register written during an active screen");
    property p_drain_wait; wrCmd && !wrData[CMD4_CLKEN_BIT] |-> sinceActive_reg >= DRAIN_CYCLES; endproperty
    a_drain_wait: assert property (p_drain_wait)
        else $error("analyzer stopped before the pipeline drained");
    property p_read_answer; rdReq |=> rdValid; endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read strobe not answered next cycle");
    property p_no_stray; rdValid |-> $past(rdReq); endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("read answer without a read strobe");
    property p_data_holds; !rdValid |-> $stable(rdData); endproperty
    a_data_holds: assert property (p_data_holds)
        else $error("read data moved between answers");
    property p_extra_zero; rdReq && cmdAddr == SIG_EXTRA_ADDR && busMode10 |=> rdData[9:3] == 7'h00; endproperty
    a_extra_zero: assert property (p_extra_zero)
        else $error("upper bits of extra word not zero");
    property p_write_cmd4; cmdValid && cmdWrite |-> cmdAddr == CMD4_ADDR; endproperty
    a_write_cmd4: assert property (p_write_cmd4)
        else $error("write to a register other than command four");
    property p_read_range; rdReq |-> cmdAddr inside {[SIG_RED_ADDR:SIG_EXTRA_ADDR]}; endproperty
    a_read_range: assert property (p_read_range)
        else $error("read outside the result words");
    property p_arm_full; wrCmd && wrData[CMD4_CLKEN_BIT] |-> wrData[CMD4_FDBK_BIT]; endproperty
    a_arm_full: assert property (p_arm_full)
        else $error("enable set without feedback");
    property p_bits_follow;
        wrCmd |=> sigClockEnable == $past(wrData[CMD4_CLKEN_BIT]) && sigFeedback == $past(wrData[CMD4_FDBK_BIT]);
    endproperty
    a_bits_follow: assert property (p_bits_follow)
        else $error("control bits did not follow the write");
    property p_reset_toggle; wrCmd && !wrData[CMD4_RESET_BIT] |-> ##[1:16] (wrCmd && wrData[CMD4_RESET_BIT]); endproperty
    a_reset_toggle: assert property (p_reset_toggle)
        else $error("reset bit not raised again");
    property p_stop_read; wrCmd && !wrData[CMD4_CLKEN_BIT] |-> ##[1:16] (rdReq && cmdAddr == SIG_RED_ADDR); endproperty
    a_stop_read: assert property (p_stop_read)
        else $error("signature not read after stopping");
endmodule

// ==== pixel_signature_analyzer_bench.sv ====
`timescale 1ns/1ns
module pixel_signature_analyzer_bench
    import psa_pkg::*;
;
    logic             core_clk, rst, blankIn, vretrace, sigClockEnable, sigFeedback;
    logic [7:0]       s_axi_awaddr, s_axi_araddr;
    logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0]      s_axi_wdata, s_axi_rdata, rdWord;
    logic [3:0]       s_axi_wstrb;
    logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
    logic [PIX_W-1:0] pixelIn;
    logic [PIX_W-1:0] pixelOut;
    logic [SIG_W-1:0] expSig;
    int               num_errors = 0;
    int               comparisons = 0;
    psa_port_if port ();
    psa_device u_psa_device (.core_clk(core_clk), .rst(rst), .port(port), .pixelIn(pixelIn), .blankIn(blankIn),
        .pixelOut(pixelOut), .sigClockEnable(sigClockEnable), .sigFeedback(sigFeedback));
    psa_host u_psa_host (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .blankIn(blankIn), .vretrace(vretrace), .port(port));
    psa_assertions u_psa_assertions (.core_clk(core_clk), .rst(rst), .cmdValid(port.cmdValid),
        .cmdWrite(port.cmdWrite), .cmdAddr(port.cmdAddr), .wrData(port.wrData), .rdData(port.rdData),
        .rdValid(port.rdValid), .busMode10(port.busMode10), .sigClockEnable(sigClockEnable),
        .sigFeedback(sigFeedback), .blankIn(blankIn));
    // free-running pixel clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // the single place where the run ends
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s response %b expected %b", $time, what, got, exp);
        end
    endtask
    // a bound that runs out counts as a mismatch and ends the run
    task automatic give_up(input string what);
        num_errors++;
        $display("[FAIL] %0t %s timed out", $time, what);
        finish_test();
    endtask
    // axi4-lite write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) give_up("write");
    endtask
    task automatic axi_read(input logic [7:0] a);
        bit done = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rdWord = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) give_up("read");
    endtask
    // arm in retrace, run one screen with a blanking gap, then collect the signature
    task automatic capture(input int base);
        logic [PIX_W-1:0] pix;
        logic [PIX_W-1:0] prevPix;
        logic             act;
        bit               done = 0;
        expSig = '0;
        axi_write(HC_CTRL_ADDR, 32'h0000_0001);
        check_resp(resp, AXI_OKAY, "arm");
        axi_read(HC_STAT_ADDR);
        check_data(rdWord & 32'h0000_0001, 32'h0000_0001, "busy");
        repeat (30) @(posedge core_clk);
        for (int k = 0; k < 72; k++) begin
            prevPix = pix;
            pix = PIX_W'(base + k * 32'h0135_79BD);
            act = !(k >= 30 && k < 38);
            @(posedge core_clk);
            vretrace <= 1'b0;
            blankIn <= act;
            pixelIn <= pix;
            // reference register: shift, fold the top stage, xor the pixel in parallel
            if (act) expSig = {expSig[31:0], 1'b0} ^ (expSig[32] ? SIG_POLY : 33'h0_0000_0000) ^ SIG_W'(pix);
        end
        @(posedge core_clk);
        // output seen at this edge is the pixel sampled one edge earlier
        check_data(32'(pixelOut), 32'(prevPix), "pixel pass-through");
        vretrace <= 1'b1;
        blankIn <= 1'b0;
        for (int i = 0; i < 40 && !done; i++) begin
            axi_read(HC_STAT_ADDR);
            done = (rdWord[HC_STAT_DONE] === 1'b1);
        end
        if (!done) give_up("capture");
        check_data(rdWord & 32'h0000_0003, 32'h0000_0002, "done status");
        axi_read(HC_SIG_LO_ADDR);
        check_data(rdWord, expSig[31:0], "signature low");
        axi_read(HC_SIG_HI_ADDR);
        check_data(rdWord, 32'(expSig[32]), "signature top");
        $display("test capture base %0d finished", base);
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        blankIn = 1'b0;
        vretrace = 1'b1;
        pixelIn = '0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        axi_read(HC_STAT_ADDR);
        check_data(rdWord, 32'h0000_0000, "status after reset");
        axi_write(HC_STAT_ADDR, 32'h0000_0001);
        check_resp(resp, AXI_SLVERR, "write to status");
        axi_read(8'h40);
        check_resp(resp, AXI_SLVERR, "unmapped read");
        check_data(rdWord, 32'h0000_0000, "unmapped data");
        $display("test access finished");
        capture(0);
        capture(32'h0ABC_0123);
        finish_test();
    end
endmodule
